// ### host_model.sv
// Purpose: Host side that drives the idle pin and the direct inputs
// Assumes: Requests come from the testbench just after a clock edge
// Notes: Pins are registered so they change after an edge only
`timescale 1ns/1ps
module host_model (
    input wire logic aclk,
    input wire logic req_idle,
    input wire logic [1:0] req_in,
    output logic idle_pin,
    output logic [1:0] direct_input_pins
);
    // Pin moves are spaced by the bench so no bus traffic overlaps them
    always @(posedge aclk) begin
        idle_pin <= req_idle;
        direct_input_pins <= req_in;
    end
endmodule : host_model

// ### op_mode_controller.sv
// Purpose: Operation-mode state machine of a relay driver, AXI4-Lite regs
// Assumes: Supply comparators and pins arrive asynchronously
// Notes: Channel stages and analog thresholds live outside this block
`timescale 1ns/1ps
// Overview of operation
// - Four modes only: sleep, idle, active and limp home.
// - Mode follows idle pin, input pins, channel-on bits, keep-active bit.
// - Sleep holds all channels off and all registers at reset.
// - A turn-on request outside active goes active or limp per idle pin.
// - Power-up needs a supply and an input or the idle pin high.
// - Power-on asserts on analog supply operative or logic supply above LOP.
// - Idle keeps channels off, diagnosis disabled, regulator running.
// - Idle with logic supply keeps registers working and accepts transfers.
// - Idle keeps channel error bits except on logic undervoltage or a host clear.
// - Active entered with idle high and any input or channel-on bit set.
// - Keep-active clear: back to idle once inputs and on bits are zero.
// - Keep-active set: stay active regardless of inputs and on bits.
// - Logic-supply undervoltage with all inputs low drops to idle.
// - A high input forces active even with both input maps zero.
// - Idle low and an input high enters limp, driving its channel.
// - Limp home ignores register writes but still answers reads.
// - Limp entry sets both supply flags and mode field to 01.
// - Transmission error reads 1 on first command after limp entry.
// - Limp clears open-load-off bits, keeps errors and monitor, others default.
// - Limp allows only channels 2 and 3, subject to supply.
// - Turn-on waits for the mode-transition latency from sleep or idle.
// - Registers reset on logic supply loss, idle low or soft reset.
// - Supply flags clear on a status read after recovery or on a soft reset.
module op_mode_controller
    import op_mode_pkg::*;
#(
    parameter int NUM_CH = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic idle_pin,
    input wire logic [1:0] direct_input_pins,
    input wire logic vs_present,
    input wire logic vs_above_uv,
    input wire logic vs_above_op,
    input wire logic vdd_present,
    input wire logic vdd_above_uv,
    input wire logic vdd_above_lop,
    input wire logic [NUM_CH-1:0] chan_err_evt,
    input wire logic [NUM_CH-1:0] osm_status,
    input wire logic [NUM_CH-1:0] open_load_off_in,
    input wire logic frame_error_evt,
    output logic [NUM_CH-1:0] chan_out,
    output logic [1:0] mode_out,
    output logic diag_enable,
    output logic regulator_on,
    output logic write_allowed,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int NS = 9;
    localparam logic [15:0] TRANS_LD = 16'(TRANS_CYC);

    // Pin synchronisers: three stages, a change counts when 2 and 3 agree
    logic [NS-1:0] raw;
    logic [NS-1:0] s1_r, s2_r, s3_r, pin_r;
    logic [NS-1:0] s1_nxt, s2_nxt, s3_nxt, pin_nxt;
    assign raw = {vdd_above_lop, vdd_above_uv, vdd_present, vs_above_op,
                  vs_above_uv, vs_present, direct_input_pins, idle_pin};
    always_comb begin
        s1_nxt = raw;
        s2_nxt = s1_r;
        s3_nxt = s2_r;
        pin_nxt = pin_r;
        for (int i = 0; i < NS; i++) begin
            if (s2_r[i] == s3_r[i]) begin
                pin_nxt[i] = s3_r[i];
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            pin_r <= '0;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
            s3_r <= s3_nxt;
            pin_r <= pin_nxt;
        end
    end

    logic idle_s, vs_ok_s, vs_uv_ok_s, vs_op_s, vdd_s, vdd_uv_ok_s, vdd_lop_s;
    logic [1:0] in_s;
    logic any_in, power_on;
    assign idle_s = pin_r[0];
    assign in_s = pin_r[2:1];
    assign vs_ok_s = pin_r[3];
    assign vs_uv_ok_s = pin_r[4];
    assign vs_op_s = pin_r[5];
    assign vdd_s = pin_r[6];
    assign vdd_uv_ok_s = pin_r[7];
    assign vdd_lop_s = pin_r[8];
    assign any_in = |in_s;
    // A supply must be up and something must be asking for the device
    assign power_on = (vs_ok_s | vdd_s) & (vs_op_s | vdd_lop_s)
                      & (any_in | idle_s);

    // Register state declared here; mode logic reads it
    logic [NUM_CH-1:0] on_r, on_nxt;
    logic [1:0] hardware_control_reg_r, hardware_control_reg_nxt;
    logic [NUM_CH-1:0] map0_r, map0_nxt, map1_r, map1_nxt;
    logic [NUM_CH-1:0] err_r, err_nxt, ol_r, ol_nxt;
    logic ter_r, ter_nxt, uv_r, uv_nxt, lop_r, lop_nxt;

    // Mode machine
    op_mode_e mode_r, mode_nxt;
    logic [15:0] settle_r, settle_nxt;
    logic [NUM_CH-1:0] chan_r, chan_nxt;
    logic [NUM_CH-1:0] mapped;
    logic limp_entry;
    always_comb begin
        mode_nxt = IDLE;
        if (!power_on) begin
            mode_nxt = SLEEP;
        end else if (!idle_s) begin
            mode_nxt = any_in ? LIMP : SLEEP;
        end else if (!vdd_uv_ok_s && !any_in) begin
            mode_nxt = IDLE;
        end else if (mode_r == ACTIVE && hardware_control_reg_r[KEEP_ACTIVE_BIT_BIT]) begin
            mode_nxt = ACTIVE;
        end else if (any_in || (|on_r)) begin
            mode_nxt = ACTIVE;
        end else begin
            mode_nxt = IDLE;
        end
        settle_nxt = settle_r;
        if ((mode_nxt == ACTIVE || mode_nxt == LIMP)
            && (mode_r == SLEEP || mode_r == IDLE)) begin
            settle_nxt = TRANS_LD;
        end else if (settle_r != 16'h0000) begin
            settle_nxt = settle_r - 16'h0001;
        end
        // Each input drives only the channels set in its map
        mapped = (in_s[0] ? map0_r : '0) | (in_s[1] ? map1_r : '0);
        chan_nxt = '0;
        if (settle_r == 16'h0000 && vs_uv_ok_s && mode_nxt == mode_r) begin
            if (mode_r == ACTIVE) begin
                chan_nxt = mapped | (vdd_uv_ok_s ? on_r : '0);
            end else if (mode_r == LIMP) begin
                for (int i = 0; i < 2; i++) begin
                    chan_nxt[LIMP_CH0 + i] = in_s[i];
                end
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_r <= SLEEP;
            settle_r <= 16'h0000;
            chan_r <= '0;
        end else begin
            mode_r <= mode_nxt;
            settle_r <= settle_nxt;
            chan_r <= chan_nxt;
        end
    end
    assign limp_entry = (mode_nxt == LIMP) && (mode_r != LIMP);
    assign chan_out = chan_r;
    assign diag_enable = (mode_r == ACTIVE) || (mode_r == LIMP);
    assign regulator_on = (mode_r != SLEEP);
    assign write_allowed = (mode_r == ACTIVE || mode_r == IDLE)
                           && vdd_uv_ok_s;
    assign mode_out = (mode_r == LIMP) ? MODE_LIMP :
                      (mode_r == ACTIVE) ? MODE_ACTIVE : MODE_IDLE;

    // AXI4-Lite slave: address and data held until both are in
    logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
    logic [7:0] awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic wlane_r, wlane_nxt;
    logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt, rd_mux;
    logic wr_fire, rd_fire, wr_hit, rd_hit, stat_read, soft_rst;
    assign s_axi_awready = !aw_full_r && !bvalid_r;
    assign s_axi_wready = !w_full_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign wr_fire = aw_full_r && w_full_r && !bvalid_r;
    assign rd_fire = s_axi_arvalid && !rvalid_r;
    assign wr_hit = (awaddr_r <= OFS_DIAG) && (awaddr_r[1:0] == 2'b00);
    assign rd_hit = (s_axi_araddr <= OFS_DIAG)
                    && (s_axi_araddr[1:0] == 2'b00);
    assign stat_read = rd_fire && (s_axi_araddr == OFS_STATUS);
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (s_axi_araddr)
            OFS_CHAN_ON: rd_mux[NUM_CH-1:0] = on_r;
            OFS_HARDWARE_CONTROL_REG: rd_mux[1:0] = hardware_control_reg_r;
            OFS_MAP0: rd_mux[NUM_CH-1:0] = map0_r;
            OFS_MAP1: rd_mux[NUM_CH-1:0] = map1_r;
            OFS_STATUS: begin
                rd_mux[ST_MODE_LSB +: 2] = mode_out;
                rd_mux[ST_TER_BIT] = ter_r;
                rd_mux[ST_UV_BIT] = uv_r;
                rd_mux[ST_LOP_BIT] = lop_r;
            end
            OFS_ERR: rd_mux[NUM_CH-1:0] = err_r;
            OFS_DIAG: begin
                rd_mux[NUM_CH-1:0] = osm_status;
                rd_mux[DIAG_OL_LSB +: NUM_CH] = ol_r;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end
    always_comb begin
        aw_full_nxt = aw_full_r;
        w_full_nxt = w_full_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        wlane_nxt = wlane_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_full_nxt = 1'b1;
            awaddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_full_nxt = 1'b1;
            wdata_nxt = s_axi_wdata;
            wlane_nxt = s_axi_wstrb[0];
        end
        if (wr_fire) begin
            aw_full_nxt = 1'b0;
            w_full_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            // Mode-refused writes still answer OKAY so the host never stalls
            bresp_nxt = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (rd_fire) begin
            rvalid_nxt = 1'b1;
            rdata_nxt = rd_mux;
            rresp_nxt = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wlane_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OKAY;
            rdata_r <= 32'h0000_0000;
        end else begin
            aw_full_r <= aw_full_nxt;
            w_full_r <= w_full_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wlane_r <= wlane_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
        end
    end
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;

    // Register file
    logic wr_ok, full_clr, cfg_clr;
    assign wr_ok = wr_fire && wlane_r && write_allowed;
    assign soft_rst = wr_ok && (awaddr_r == OFS_HARDWARE_CONTROL_REG)
                      && wdata_r[SOFT_RESET_BIT_BIT];
    // Loss of logic supply wipes everything, error bits included
    assign full_clr = (mode_nxt == SLEEP) || !vdd_uv_ok_s;
    assign cfg_clr = full_clr || soft_rst || !idle_s
                     || (mode_r == LIMP);
    always_comb begin
        on_nxt = on_r;
        hardware_control_reg_nxt = hardware_control_reg_r;
        map0_nxt = map0_r;
        map1_nxt = map1_r;
        err_nxt = err_r;
        ol_nxt = ol_r;
        ter_nxt = ter_r;
        uv_nxt = uv_r;
        lop_nxt = lop_r;
        if (wr_ok) begin
            unique case (awaddr_r)
                OFS_CHAN_ON: on_nxt = wdata_r[NUM_CH-1:0];
                OFS_HARDWARE_CONTROL_REG: hardware_control_reg_nxt[KEEP_ACTIVE_BIT_BIT] = wdata_r[KEEP_ACTIVE_BIT_BIT];
                OFS_MAP0: map0_nxt = wdata_r[NUM_CH-1:0];
                OFS_MAP1: map1_nxt = wdata_r[NUM_CH-1:0];
                OFS_ERR: err_nxt = err_r & ~wdata_r[NUM_CH-1:0];
                default: ;
            endcase
        end
        // Read and soft-reset clears first, then events so a set in the same cycle wins; a full clear comes last
        if (stat_read) begin
            ter_nxt = 1'b0;
            if (vs_op_s) begin
                uv_nxt = 1'b0;
            end
            if (vdd_lop_s) begin
                lop_nxt = 1'b0;
            end
        end
        if (cfg_clr) begin
            on_nxt = CHAN_ON_RST;
            hardware_control_reg_nxt = SOFT_RESET_BIT;
            map0_nxt = MAP_RST;
            map1_nxt = MAP_RST;
        end
        if (soft_rst) begin
            uv_nxt = 1'b0;
            lop_nxt = 1'b0;
        end
        if (diag_enable) begin
            err_nxt = err_nxt | chan_err_evt;
            ol_nxt = (mode_r == LIMP) ? '0 : open_load_off_in;
        end
        if (mode_r != SLEEP && !vs_uv_ok_s) begin
            uv_nxt = 1'b1;
        end
        if (vdd_uv_ok_s && !vdd_lop_s) begin
            lop_nxt = 1'b1;
        end
        if (frame_error_evt) begin
            ter_nxt = 1'b1;
        end
        if (limp_entry) begin
            uv_nxt = 1'b1;
            lop_nxt = 1'b1;
            ter_nxt = 1'b1;
        end
        if (full_clr) begin
            err_nxt = '0;
            ol_nxt = '0;
            ter_nxt = 1'b0;
            uv_nxt = 1'b0;
            lop_nxt = 1'b0;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            on_r <= CHAN_ON_RST;
            hardware_control_reg_r <= SOFT_RESET_BIT;
            map0_r <= MAP_RST;
            map1_r <= MAP_RST;
            err_r <= '0;
            ol_r <= '0;
            ter_r <= 1'b0;
            uv_r <= 1'b0;
            lop_r <= 1'b0;
        end else begin
            on_r <= on_nxt;
            hardware_control_reg_r <= hardware_control_reg_nxt;
            map0_r <= map0_nxt;
            map1_r <= map1_nxt;
            err_r <= err_nxt;
            ol_r <= ol_nxt;
            ter_r <= ter_nxt;
            uv_r <= uv_nxt;
            lop_r <= lop_nxt;
        end
    end
endmodule : op_mode_controller

// ### op_mode_pkg.sv
// Purpose: Shared constants for the operation-mode controller
// Assumes: 32-bit AXI4-Lite register bus, 200 MHz aclk
// Notes: All offsets are byte addresses
package op_mode_pkg;
    localparam int CLK_MHZ = 200;
    // Mode-transition latency, in ns
    localparam int TRANS_NS = 1000;
    localparam int TRANS_CYC = (TRANS_NS * CLK_MHZ + 999) / 1000;
    localparam logic [7:0] OFS_CHAN_ON = 8'h00;
    localparam logic [7:0] OFS_HARDWARE_CONTROL_REG = 8'h04;
    localparam logic [7:0] OFS_MAP0 = 8'h08;
    localparam logic [7:0] OFS_MAP1 = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_ERR = 8'h14;
    localparam logic [7:0] OFS_DIAG = 8'h18;
    localparam int KEEP_ACTIVE_BIT_BIT = 0;
    localparam int SOFT_RESET_BIT_BIT = 1;
    localparam int ST_MODE_LSB = 0;
    localparam int ST_TER_BIT = 2;
    localparam int ST_UV_BIT = 3;
    localparam int ST_LOP_BIT = 4;
    localparam int DIAG_OL_LSB = 16;
    localparam logic [1:0] MODE_IDLE = 2'b00;
    localparam logic [1:0] MODE_LIMP = 2'b01;
    localparam logic [1:0] MODE_ACTIVE = 2'b10;
    localparam logic [7:0] CHAN_ON_RST = 8'h00;
    localparam logic [1:0] SOFT_RESET_BIT = 2'h0;
    localparam logic [7:0] MAP_RST = 8'h00;
    localparam int LIMP_CH0 = 2;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [1:0] {
        SLEEP,
        IDLE,
        ACTIVE,
        LIMP
    } op_mode_e;
endpackage : op_mode_pkg

// ### op_mode_properties.sv
// Purpose: Port-level checks of the operation-mode controller
// Assumes: Pins held steady for eight cycles before a mode is judged
// Notes: Bound into the design from the testbench top file
`timescale 1ns/1ps
module op_mode_properties
    import op_mode_pkg::*;
#(
    parameter int NUM_CH = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic idle_pin,
    input wire logic [1:0] direct_input_pins,
    input wire logic vdd_present,
    input wire logic vdd_above_uv,
    input wire logic vdd_above_lop,
    input wire logic [NUM_CH-1:0] chan_out,
    input wire logic [1:0] mode_out,
    input wire logic diag_enable,
    input wire logic regulator_on,
    input wire logic write_allowed
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Eight steady cycles cover the pin synchroniser and the mode register
    sequence run_req;
        (idle_pin && direct_input_pins != 2'b00 && vdd_present &&
            vdd_above_uv && vdd_above_lop)[*8];
    endsequence
    sequence limp_req;
        (!idle_pin && direct_input_pins != 2'b00 && vdd_present &&
            vdd_above_lop)[*8];
    endsequence
    sequence sleep_req;
        (!idle_pin && direct_input_pins == 2'b00)[*8];
    endsequence
    sleep_off_a: assert property (!regulator_on |-> chan_out == '0 &&
        !write_allowed && !diag_enable) else $error("sleep output active");
    idle_off_a: assert property (regulator_on && !diag_enable |->
        chan_out == '0) else $error("channel on in idle");
    mode_code_a: assert property (diag_enable ==
        (mode_out == MODE_LIMP || mode_out == MODE_ACTIVE))
        else $error("mode code and diagnosis disagree");
    limp_chan_a: assert property ((mode_out == MODE_LIMP)[*2] |->
        (chan_out & ~NUM_CH'(12)) == '0) else $error("bad limp channel");
    limp_ro_a: assert property (mode_out == MODE_LIMP |->
        !write_allowed) else $error("write allowed in limp");
    active_entry_a: assert property (run_req |->
        mode_out == MODE_ACTIVE) else $error("active not entered");
    limp_entry_a: assert property (limp_req |->
        mode_out == MODE_LIMP) else $error("limp not entered");
    sleep_entry_a: assert property (sleep_req |->
        !regulator_on) else $error("sleep not entered");
    idle_write_a: assert property (vdd_above_uv[*8] ##0
        (regulator_on && !diag_enable) |-> write_allowed)
        else $error("idle refuses writes");
    turn_on_wait_a: assert property ($rose(diag_enable) |->
        (chan_out == '0)[*8]) else $error("turn-on without latency");
endmodule : op_mode_properties

// ### tb.sv
// Purpose: Self-checking bench of the operation-mode controller
// Assumes: Register bus master is this bench; supplies dip in s_diag only
// Notes: Checker is bound at the foot of this file
`timescale 1ns/1ps
module tb
    import op_mode_pkg::*;
;
    logic aclk, aresetn, req_idle, idle_pin, diag, reg_on, wr_ok;
    logic [1:0] req_in, pins_in, mode, bresp, rresp, rsp;
    logic vs_p, vs_uv, vs_op, vdd_p, vdd_uv, vdd_lop;
    logic [7:0] chan, awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, rd_v;
    logic [3:0] wstrb;
    logic [7:0] err_evt, osm, olo;
    logic ter_evt;
    int n_mismatch = 0;
    int checked = 0;
    host_model host (.aclk(aclk), .req_idle(req_idle), .req_in(req_in),
        .idle_pin(idle_pin), .direct_input_pins(pins_in));
    op_mode_controller #(.NUM_CH(8)) dut (.aclk(aclk), .aresetn(aresetn),
        .idle_pin(idle_pin), .direct_input_pins(pins_in),
        .vs_present(vs_p), .vs_above_uv(vs_uv), .vs_above_op(vs_op),
        .vdd_present(vdd_p), .vdd_above_uv(vdd_uv),
        .vdd_above_lop(vdd_lop), .chan_err_evt(err_evt), .osm_status(osm),
        .open_load_off_in(olo), .frame_error_evt(ter_evt), .chan_out(chan),
        .mode_out(mode), .diag_enable(diag), .regulator_on(reg_on),
        .write_allowed(wr_ok), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    task automatic test_done();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done
    task automatic wt(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask : wt
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // No cycle count assumed; only the watchdog ends a hung transfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        rsp = bresp;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        rd_v = rdata;
        rsp = rresp;
    endtask : rd
    // Twelve cycles let the pins clear the synchroniser before traffic
    task automatic pins(input logic i, input logic [1:0] d);
        @(posedge aclk);
        req_idle <= i;
        req_in <= d;
        wt(12);
    endtask : pins
    task automatic s_power();
        wt(2);
        chk("regulator", 0, reg_on);
        pins(1'b1, 2'b00);
        chk("regulator", 1, reg_on);
        chk("diagnosis", 0, diag);
        chk("write_allowed", 1, wr_ok);
        rd(8'h1c);
        chk("unmapped resp", RESP_SLVERR, rsp);
        chk("unmapped data", 0, rd_v);
    endtask : s_power
    task automatic s_active();
        wr(OFS_CHAN_ON, 32'h1);
        wt(2);
        chk("chan early", 0, chan);
        wt(TRANS_CYC + 8);
        chk("chan on", 1, chan);
        rd(OFS_STATUS);
        chk("mode field", MODE_ACTIVE, rd_v & 32'h3);
        wr(OFS_HARDWARE_CONTROL_REG, 32'h1);
        wr(OFS_CHAN_ON, 32'h0);
        wt(8);
        chk("mode kept", MODE_ACTIVE, mode);
        wr(OFS_HARDWARE_CONTROL_REG, 32'h0);
        wt(8);
        chk("mode back", MODE_IDLE, mode);
        wr(OFS_CHAN_ON, 32'h81);
        wr(OFS_HARDWARE_CONTROL_REG, 32'h2);
        rd(OFS_CHAN_ON);
        chk("on bits soft", 0, rd_v);
        pins(1'b1, 2'b01);
        chk("mode unmapped", MODE_ACTIVE, mode);
        pins(1'b1, 2'b00);
        chk("mode idle", MODE_IDLE, mode);
    endtask : s_active
    task automatic s_diag();
        wr(OFS_MAP0, 32'h30);
        pins(1'b1, 2'b01);
        wt(TRANS_CYC);
        chk("chan mapped", 8'h30, chan);
        @(posedge aclk);
        err_evt <= 8'h05;
        osm <= 8'h5a;
        olo <= 8'h81;
        ter_evt <= 1'b1;
        @(posedge aclk);
        err_evt <= 8'h00;
        ter_evt <= 1'b0;
        rd(OFS_ERR);
        chk("err bits", 32'h05, rd_v);
        rd(OFS_DIAG);
        chk("diag word", 32'h0081_005a, rd_v);
        rd(OFS_STATUS);
        chk("ter set", 32'h06, rd_v & 32'h1f);
        pins(1'b1, 2'b00);
        // Error events while idle must be ignored
        @(posedge aclk);
        err_evt <= 8'h10;
        @(posedge aclk);
        err_evt <= 8'h00;
        rd(OFS_ERR);
        chk("err idle", 32'h05, rd_v);
        wr(OFS_ERR, 32'h01);
        rd(OFS_ERR);
        chk("err clear", 32'h04, rd_v);
        wr(OFS_CHAN_ON, 32'h1);
        wr(OFS_HARDWARE_CONTROL_REG, 32'h1);
        @(posedge aclk);
        vdd_uv <= 1'b0;
        wt(12);
        chk("mode uv", MODE_IDLE, mode);
        chk("write uv", 0, wr_ok);
        @(posedge aclk);
        vdd_uv <= 1'b1;
        vs_uv <= 1'b0;
        wt(8);
        rd(OFS_CHAN_ON);
        chk("on bits uv", 0, rd_v);
        @(posedge aclk);
        vs_uv <= 1'b1;
        wt(8);
        rd(OFS_STATUS);
        chk("uv flag", 32'h08, rd_v & 32'h1f);
        rd(OFS_STATUS);
        chk("uv clear", 32'h00, rd_v & 32'h1f);
    endtask : s_diag
    task automatic s_limp();
        pins(1'b0, 2'b01);
        chk("mode limp", MODE_LIMP, mode);
        chk("write_allowed", 0, wr_ok);
        wt(TRANS_CYC);
        chk("chan limp", 8'h04, chan);
        rd(OFS_STATUS);
        chk("status entry", 32'h1d, rd_v & 32'h1f);
        rd(OFS_STATUS);
        chk("status next", 32'h01, rd_v & 32'h1f);
        wr(OFS_CHAN_ON, 32'hff);
        chk("limp resp", RESP_OKAY, rsp);
        rd(OFS_CHAN_ON);
        chk("limp on bits", 0, rd_v);
        rd(OFS_DIAG);
        chk("limp diag", 32'h5a, rd_v);
        pins(1'b0, 2'b11);
        chk("chan both", 8'h0c, chan);
        pins(1'b0, 2'b00);
        chk("regulator", 0, reg_on);
        chk("chan sleep", 0, chan);
    endtask : s_limp
    initial begin
        aresetn = 1'b0;
        req_idle = 1'b0;
        req_in = 2'b00;
        {vs_p, vs_uv, vs_op, vdd_p, vdd_uv, vdd_lop} = 6'h3f;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'hf;
        err_evt = 8'h00;
        osm = 8'h00;
        olo = 8'h00;
        ter_evt = 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        s_power();
        s_active();
        s_diag();
        s_limp();
        test_done();
    end
    // Whole run needs about nine hundred cycles
    initial begin
        repeat (8000) @(posedge aclk);
        n_mismatch++;
        test_done();
    end
endmodule : tb
bind op_mode_controller op_mode_properties #(.NUM_CH(NUM_CH)) chk_i (
    .aclk(aclk), .aresetn(aresetn), .idle_pin(idle_pin),
    .direct_input_pins(direct_input_pins), .vdd_present(vdd_present),
    .vdd_above_uv(vdd_above_uv), .vdd_above_lop(vdd_above_lop),
    .chan_out(chan_out), .mode_out(mode_out), .diag_enable(diag_enable),
    .regulator_on(regulator_on), .write_allowed(write_allowed));
